// *** verilog/gsmux_defs.vh ***
// register map, field layout, function codes and timing for the pin mux
`ifndef GSMUX_DEFS_VH
`define GSMUX_DEFS_VH

`define GSMUX_ADDR_W 4
`define GSMUX_DATA_W 32

// register indices
`define GSMUX_REG_PIN1_CFG 4'h0
`define GSMUX_REG_PIN2_CFG 4'h1
`define GSMUX_REG_CORE_CLK 4'h2
`define GSMUX_REG_SEC_CLK 4'h3
`define GSMUX_REG_LOOP_CLK 4'h4
`define GSMUX_REG_PWM_CFG 4'h5
`define GSMUX_REG_PWM_DUTY 4'h6
`define GSMUX_REG_EVT_STS 4'h8
`define GSMUX_REG_RAW_STS 4'h9

// pin configuration fields
`define GSMUX_FN_MSB 6
`define GSMUX_FN_LSB 0
`define GSMUX_POL_BIT 8
`define GSMUX_DIR_BIT 9
`define GSMUX_PIN_CFG_W 10

// clock output configuration fields
`define GSMUX_DIV_MSB 3
`define GSMUX_DIV_LSB 0
`define GSMUX_SRC_MSB 5
`define GSMUX_SRC_LSB 4
`define GSMUX_CLK_EN_BIT 8

// loop pin clock fields
`define GSMUX_L1_DIV_MSB 3
`define GSMUX_L1_DIV_LSB 0
`define GSMUX_L1_EN_BIT 4
`define GSMUX_L2_DIV_MSB 11
`define GSMUX_L2_DIV_LSB 8
`define GSMUX_L2_EN_BIT 12

// pulse generator fields
`define GSMUX_PWM1_EN_BIT 0
`define GSMUX_PWM2_EN_BIT 1
`define GSMUX_PWM1_AUD_BIT 2
`define GSMUX_PWM2_AUD_BIT 3
`define GSMUX_DUTY1_MSB 7
`define GSMUX_DUTY1_LSB 0
`define GSMUX_DUTY2_MSB 15
`define GSMUX_DUTY2_LSB 8

// reset values
`define GSMUX_PIN_CFG_RST 10'h200
`define GSMUX_CLK_CFG_RST 9'h000
`define GSMUX_LOOP_CFG_RST 13'h0000
`define GSMUX_PWM_CFG_RST 4'h0
`define GSMUX_DUTY_RST 16'h0000

// event and raw status bit positions
`define GSMUX_EV_DSP_LSB 0
`define GSMUX_EV_DSP_MSB 7
`define GSMUX_EV_RAM_LSB 8
`define GSMUX_EV_RAM_MSB 9
`define GSMUX_EV_OK_LSB 10
`define GSMUX_EV_OK_MSB 11
`define GSMUX_EV_LOCK_LSB 12
`define GSMUX_EV_LOCK_MSB 13
`define GSMUX_EV_HP_ON 14
`define GSMUX_EV_HP_OFF 15
`define GSMUX_EV_BOOT 16
`define GSMUX_EV_RCL_LSB 17
`define GSMUX_EV_RCL_MSB 18
`define GSMUX_EV_RERR 19
`define GSMUX_EV_W 20

// pin function codes
`define GSMUX_FN_CORE_CLK 7'h04
`define GSMUX_FN_LOOP1_CLK 7'h05
`define GSMUX_FN_LOOP2_CLK 7'h06
`define GSMUX_FN_PWM1 7'h08
`define GSMUX_FN_PWM2 7'h09
`define GSMUX_FN_LOOP1_OK 7'h0c
`define GSMUX_FN_LOOP2_OK 7'h0d
`define GSMUX_FN_LOOP1_LOCK 7'h0f
`define GSMUX_FN_LOOP2_LOCK 7'h10
`define GSMUX_FN_RCL1 7'h1a
`define GSMUX_FN_RCL2 7'h1b
`define GSMUX_FN_RERR 7'h1c
`define GSMUX_FN_HP_ON 7'h2f
`define GSMUX_FN_HP_OFF 7'h30
`define GSMUX_FN_DSP1 7'h35
`define GSMUX_FN_DSP2 7'h36
`define GSMUX_FN_DSP3 7'h37
`define GSMUX_FN_DSP4 7'h38
`define GSMUX_FN_DSP5 7'h39
`define GSMUX_FN_DSP6 7'h3a
`define GSMUX_FN_DSP7 7'h3b
`define GSMUX_FN_DSP8 7'h3c
`define GSMUX_FN_SEC_CLK 7'h3d
`define GSMUX_FN_BOOT 7'h44
`define GSMUX_FN_RAM1 7'h46
`define GSMUX_FN_RAM2 7'h47

// timing
`define GSMUX_CLK_KHZ 20000
`define GSMUX_PULSE_NS 100
`define GSMUX_PULSE_CYC ((`GSMUX_PULSE_NS * `GSMUX_CLK_KHZ + 999999) / 1000000)
`define GSMUX_RATE_MAX_HZ 18'd48000
`define GSMUX_BOOT_CYCLES 64

`endif

// *** verilog/gsmux_clkdiv.v ***
// gated toggle divider clocked by one-cycle source ticks
`timescale 1ns/1ps
module gsmux_clkdiv #(
   parameter DIV_W = 4
) (
   input wire clock,
   input wire rst_n,
   input wire tick,
   input wire enable,
   input wire [DIV_W-1:0] divider,
   output reg clk_out_r
);
   reg [DIV_W-1:0] cnt_r;

   // disabling parks the output low so a divider change starts clean
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {DIV_W{1'b0}};
         clk_out_r <= 1'b0;
      end else if (!enable) begin
         cnt_r <= {DIV_W{1'b0}};
         clk_out_r <= 1'b0;
      end else if (tick) begin
         if (cnt_r == divider) begin
            cnt_r <= {DIV_W{1'b0}};
            clk_out_r <= ~clk_out_r;
         end else begin
            cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // gsmux_clkdiv

// *** verilog/gsmux_top.v ***
// status and clock output mux for two general-purpose pins
// Functional notes
// RL1: dsp and ram flags latch on rise
// RL2: latched event bits stay set, pollable
// RL3: code 04h gives divided core clock
// RL4: code 3Dh gives divided secondary clock
// RL5: host disables clock before divider change
// RL6: host keeps source at or below clock
// RL7: loop ok and lock codes give status
// RL8: loop status latches both edges
// RL9: loop pin divider touches pin only
// RL10: host disables loop clock before change
// RL11: pulse generators, audio or fixed duty
// RL12: host disables generators without core clock
// RL13: headphone done gives 100ns pulse
// RL14: headphone sequence completion latches event
// RL15: boot runs after reset, status one
// RL16: host writes nothing during boot
// RL17: code 44h pulses at boot end
// RL18: boot done rise latches event
// RL19: converter lock codes, both edges latched
// RL20: config error above 48kHz rates
// RL21: config error rise latches event
// RL22: polarity bit inverts selected output
// RL23: eight dsp flags, two ram flags
// RL24: latched bits clear only by software
// RL25: pulse returns low until next event
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "gsmux_defs.vh"
module gsmux_top #(
   parameter BOOT_CYCLES = `GSMUX_BOOT_CYCLES,
   parameter [`GSMUX_PIN_CFG_W-1:0] BOOT_PIN1_CFG = `GSMUX_PIN_CFG_RST,
   parameter [`GSMUX_PIN_CFG_W-1:0] BOOT_PIN2_CFG = `GSMUX_PIN_CFG_RST,
   parameter DIV_W = 4,
   parameter PWM_W = 8
) (
   input wire clock,
   input wire rst_n,
   input wire [`GSMUX_ADDR_W-1:0] reg_addr,
   input wire [`GSMUX_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`GSMUX_DATA_W-1:0] reg_rdata_r,
   input wire [7:0] dsp_status_flag,
   input wire [1:0] dsp_ram_ready,
   input wire [1:0] loop_clock_ok,
   input wire [1:0] loop_lock,
   input wire [1:0] loop_clock,
   input wire secondary_system_clock,
   input wire [1:0] rate_conv_lock,
   input wire [17:0] rate_conv_in_hz,
   input wire [17:0] rate_conv_out_hz,
   input wire hp_on_seq_done,
   input wire hp_off_seq_done,
   input wire [PWM_W-1:0] pwm_audio_a,
   input wire [PWM_W-1:0] pwm_audio_b,
   output reg pin1_out_r,
   output reg pin1_oe_r,
   output reg pin2_out_r,
   output reg pin2_oe_r,
   output reg boot_complete_status_r,
   output reg event_pending_r
);
   localparam ASYNC_W = 19;
   localparam A_DSP = 0;
   localparam A_RAM = 8;
   localparam A_OK = 10;
   localparam A_LOCK = 12;
   localparam A_RCL = 14;
   localparam A_SEC = 16;
   localparam A_LCLK = 17;
   localparam PULSE_LOAD = `GSMUX_PULSE_CYC;
   localparam BOOT_LAST = BOOT_CYCLES - 1;

   // synchronisers
   wire [ASYNC_W-1:0] async_in;
   reg [ASYNC_W-1:0] sy1_r;
   reg [ASYNC_W-1:0] sy2_r;
   reg [ASYNC_W-1:0] sy3_r;
   reg [ASYNC_W-1:0] stable_r;
   reg [ASYNC_W-1:0] stable_d_r;
   wire [ASYNC_W-1:0] stable_nxt;
   wire [ASYNC_W-1:0] rise;
   wire [ASYNC_W-1:0] fall;

   assign async_in = {loop_clock, secondary_system_clock, rate_conv_lock,
                      loop_lock, loop_clock_ok, dsp_ram_ready,
                      dsp_status_flag};
   // a change is taken only once stages two and three agree
   assign stable_nxt = (sy2_r & sy3_r) | (stable_r & (sy2_r | sy3_r));
   assign rise = stable_r & ~stable_d_r;
   assign fall = ~stable_r & stable_d_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sy1_r <= {ASYNC_W{1'b0}};
         sy2_r <= {ASYNC_W{1'b0}};
         sy3_r <= {ASYNC_W{1'b0}};
         stable_r <= {ASYNC_W{1'b0}};
         stable_d_r <= {ASYNC_W{1'b0}};
      end else begin
         sy1_r <= async_in;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         stable_r <= stable_nxt;
         stable_d_r <= stable_r;
      end
   end

   // boot sequence
   reg [15:0] boot_cnt_r;
   reg boot_fin_r;

   // RL15: boot after reset
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         boot_cnt_r <= 16'h0000;
         boot_complete_status_r <= 1'b0;
         boot_fin_r <= 1'b0;
      end else begin
         boot_fin_r <= 1'b0;
         if (!boot_complete_status_r) begin
            if (boot_cnt_r == BOOT_LAST[15:0]) begin
               boot_complete_status_r <= 1'b1;
               boot_fin_r <= 1'b1;
            end else begin
               boot_cnt_r <= boot_cnt_r + 16'h0001;
            end
         end
      end
   end

   // register file
   reg [`GSMUX_PIN_CFG_W-1:0] pin1_cfg_r;
   reg [`GSMUX_PIN_CFG_W-1:0] pin2_cfg_r;
   reg [8:0] core_cfg_r;
   reg [8:0] sec_cfg_r;
   reg [12:0] loop_cfg_r;
   reg [3:0] pwm_cfg_r;
   reg [15:0] duty_r;
   reg [`GSMUX_EV_W-1:0] evt_r;
   reg [`GSMUX_EV_W-1:0] evt_set;
   reg [`GSMUX_EV_W-1:0] evt_clr;
   reg [`GSMUX_EV_W-1:0] raw_sts;
   reg rerr_r;
   reg rerr_d_r;
   wire wr_ok;

   // RL16: config writes before boot end are dropped
   assign wr_ok = reg_wr & boot_complete_status_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin1_cfg_r <= `GSMUX_PIN_CFG_RST;
         pin2_cfg_r <= `GSMUX_PIN_CFG_RST;
         core_cfg_r <= `GSMUX_CLK_CFG_RST;
         sec_cfg_r <= `GSMUX_CLK_CFG_RST;
         loop_cfg_r <= `GSMUX_LOOP_CFG_RST;
         pwm_cfg_r <= `GSMUX_PWM_CFG_RST;
         duty_r <= `GSMUX_DUTY_RST;
      end else if (boot_fin_r) begin
         // RL17: boot may assign pin functions
         pin1_cfg_r <= BOOT_PIN1_CFG;
         pin2_cfg_r <= BOOT_PIN2_CFG;
      end else if (wr_ok) begin
         case (reg_addr)
            `GSMUX_REG_PIN1_CFG: pin1_cfg_r <= reg_wdata[9:0];
            `GSMUX_REG_PIN2_CFG: pin2_cfg_r <= reg_wdata[9:0];
            `GSMUX_REG_CORE_CLK: core_cfg_r <= reg_wdata[8:0];
            `GSMUX_REG_SEC_CLK: sec_cfg_r <= reg_wdata[8:0];
            `GSMUX_REG_LOOP_CLK: loop_cfg_r <= reg_wdata[12:0];
            `GSMUX_REG_PWM_CFG: pwm_cfg_r <= reg_wdata[3:0];
            `GSMUX_REG_PWM_DUTY: duty_r <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end

   // RL20: any rate above limit flags error
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rerr_r <= 1'b0;
         rerr_d_r <= 1'b0;
      end else begin
         rerr_r <= (rate_conv_in_hz > `GSMUX_RATE_MAX_HZ) |
                   (rate_conv_out_hz > `GSMUX_RATE_MAX_HZ);
         rerr_d_r <= rerr_r;
      end
   end

   always @* begin
      evt_set = {`GSMUX_EV_W{1'b0}};
      // RL1: rising dsp and ram flags
      evt_set[`GSMUX_EV_DSP_MSB:`GSMUX_EV_DSP_LSB] = rise[A_DSP+7:A_DSP];
      evt_set[`GSMUX_EV_RAM_MSB:`GSMUX_EV_RAM_LSB] = rise[A_RAM+1:A_RAM];
      // RL8: both edges of loop status
      evt_set[`GSMUX_EV_OK_MSB:`GSMUX_EV_OK_LSB] =
         rise[A_OK+1:A_OK] | fall[A_OK+1:A_OK];
      evt_set[`GSMUX_EV_LOCK_MSB:`GSMUX_EV_LOCK_LSB] =
         rise[A_LOCK+1:A_LOCK] | fall[A_LOCK+1:A_LOCK];
      // RL14: headphone sequence completion
      evt_set[`GSMUX_EV_HP_ON] = hp_on_seq_done;
      evt_set[`GSMUX_EV_HP_OFF] = hp_off_seq_done;
      // RL18: boot done rise
      evt_set[`GSMUX_EV_BOOT] = boot_fin_r;
      // RL19: converter lock both edges
      evt_set[`GSMUX_EV_RCL_MSB:`GSMUX_EV_RCL_LSB] =
         rise[A_RCL+1:A_RCL] | fall[A_RCL+1:A_RCL];
      // RL21: config error rise
      evt_set[`GSMUX_EV_RERR] = rerr_r & ~rerr_d_r;
   end

   always @* begin
      evt_clr = {`GSMUX_EV_W{1'b0}};
      if (wr_ok && reg_addr == `GSMUX_REG_EVT_STS) begin
         evt_clr = reg_wdata[`GSMUX_EV_W-1:0];
      end
   end

   // RL2: sticky bits, set beats clear
   // RL24: only a write of one clears
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         evt_r <= {`GSMUX_EV_W{1'b0}};
         event_pending_r <= 1'b0;
      end else begin
         evt_r <= (evt_r & ~evt_clr) | evt_set;
         event_pending_r <= |evt_r;
      end
   end

   // RL23: eight dsp flags, two ram flags
   always @* begin
      raw_sts = {`GSMUX_EV_W{1'b0}};
      raw_sts[`GSMUX_EV_DSP_MSB:`GSMUX_EV_DSP_LSB] = stable_r[A_DSP+7:A_DSP];
      raw_sts[`GSMUX_EV_RAM_MSB:`GSMUX_EV_RAM_LSB] = stable_r[A_RAM+1:A_RAM];
      raw_sts[`GSMUX_EV_OK_MSB:`GSMUX_EV_OK_LSB] = stable_r[A_OK+1:A_OK];
      raw_sts[`GSMUX_EV_LOCK_MSB:`GSMUX_EV_LOCK_LSB] =
         stable_r[A_LOCK+1:A_LOCK];
      raw_sts[`GSMUX_EV_BOOT] = boot_complete_status_r;
      raw_sts[`GSMUX_EV_RCL_MSB:`GSMUX_EV_RCL_LSB] = stable_r[A_RCL+1:A_RCL];
      raw_sts[`GSMUX_EV_RERR] = rerr_r;
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= {`GSMUX_DATA_W{1'b0}};
      end else if (reg_rd) begin
         case (reg_addr)
            `GSMUX_REG_PIN1_CFG: reg_rdata_r <= {22'h000000, pin1_cfg_r};
            `GSMUX_REG_PIN2_CFG: reg_rdata_r <= {22'h000000, pin2_cfg_r};
            `GSMUX_REG_CORE_CLK: reg_rdata_r <= {23'h000000, core_cfg_r};
            `GSMUX_REG_SEC_CLK: reg_rdata_r <= {23'h000000, sec_cfg_r};
            `GSMUX_REG_LOOP_CLK: reg_rdata_r <= {19'h00000, loop_cfg_r};
            `GSMUX_REG_PWM_CFG: reg_rdata_r <= {28'h0000000, pwm_cfg_r};
            `GSMUX_REG_PWM_DUTY: reg_rdata_r <= {16'h0000, duty_r};
            `GSMUX_REG_EVT_STS: reg_rdata_r <= {12'h000, evt_r};
            `GSMUX_REG_RAW_STS: reg_rdata_r <= {12'h000, raw_sts};
            default: reg_rdata_r <= {`GSMUX_DATA_W{1'b0}};
         endcase
      end else begin
         reg_rdata_r <= {`GSMUX_DATA_W{1'b0}};
      end
   end

   // clock outputs
   reg [2:0] core_pre_r;
   reg [2:0] sec_pre_r;
   wire core_tick;
   wire sec_tick;
   wire core_clk_out;
   wire sec_clk_out;
   wire loop1_clk_out;
   wire loop2_clk_out;

   // source select: base rate divided by 1, 2, 4 or 8
   function src_tick;
      input [1:0] sel;
      input [2:0] cnt;
      input base;
      begin
         case (sel)
            2'h0: src_tick = base;
            2'h1: src_tick = base & cnt[0];
            2'h2: src_tick = base & (&cnt[1:0]);
            default: src_tick = base & (&cnt);
         endcase
      end
   endfunction

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_pre_r <= 3'h0;
         sec_pre_r <= 3'h0;
      end else begin
         core_pre_r <= core_pre_r + 3'h1;
         if (rise[A_SEC]) begin
            sec_pre_r <= sec_pre_r + 3'h1;
         end
      end
   end

   // sources can never exceed their clock, which covers the host side
   // RL6: source never above its clock
   assign core_tick = src_tick(core_cfg_r[`GSMUX_SRC_MSB:`GSMUX_SRC_LSB],
                               core_pre_r, 1'b1);
   assign sec_tick = src_tick(sec_cfg_r[`GSMUX_SRC_MSB:`GSMUX_SRC_LSB],
                              sec_pre_r, rise[A_SEC]);

   // RL3: core derived clock
   gsmux_clkdiv #(.DIV_W(DIV_W)) u_core_div (
      .clock(clock),
      .rst_n(rst_n),
      .tick(core_tick),
      .enable(core_cfg_r[`GSMUX_CLK_EN_BIT]),
      .divider(core_cfg_r[`GSMUX_DIV_MSB:`GSMUX_DIV_LSB]),
      .clk_out_r(core_clk_out)
   );

   // RL4: secondary derived clock
   gsmux_clkdiv #(.DIV_W(DIV_W)) u_sec_div (
      .clock(clock),
      .rst_n(rst_n),
      .tick(sec_tick),
      .enable(sec_cfg_r[`GSMUX_CLK_EN_BIT]),
      .divider(sec_cfg_r[`GSMUX_DIV_MSB:`GSMUX_DIV_LSB]),
      .clk_out_r(sec_clk_out)
   );

   // RL9: pin-only dividers on loop clocks
   gsmux_clkdiv #(.DIV_W(DIV_W)) u_loop1_div (
      .clock(clock),
      .rst_n(rst_n),
      .tick(rise[A_LCLK]),
      .enable(loop_cfg_r[`GSMUX_L1_EN_BIT]),
      .divider(loop_cfg_r[`GSMUX_L1_DIV_MSB:`GSMUX_L1_DIV_LSB]),
      .clk_out_r(loop1_clk_out)
   );

   gsmux_clkdiv #(.DIV_W(DIV_W)) u_loop2_div (
      .clock(clock),
      .rst_n(rst_n),
      .tick(rise[A_LCLK+1]),
      .enable(loop_cfg_r[`GSMUX_L2_EN_BIT]),
      .divider(loop_cfg_r[`GSMUX_L2_DIV_MSB:`GSMUX_L2_DIV_LSB]),
      .clk_out_r(loop2_clk_out)
   );

   // pulse generators
   reg [PWM_W-1:0] pwm_cnt_r;
   reg pwm1_r;
   reg pwm2_r;
   wire [PWM_W-1:0] duty1;
   wire [PWM_W-1:0] duty2;

   // RL11: audio modulated or fixed duty
   assign duty1 = pwm_cfg_r[`GSMUX_PWM1_AUD_BIT] ? pwm_audio_a :
                  duty_r[`GSMUX_DUTY1_MSB:`GSMUX_DUTY1_LSB];
   assign duty2 = pwm_cfg_r[`GSMUX_PWM2_AUD_BIT] ? pwm_audio_b :
                  duty_r[`GSMUX_DUTY2_MSB:`GSMUX_DUTY2_LSB];

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pwm_cnt_r <= {PWM_W{1'b0}};
         pwm1_r <= 1'b0;
         pwm2_r <= 1'b0;
      end else begin
         pwm_cnt_r <= pwm_cnt_r + {{(PWM_W-1){1'b0}}, 1'b1};
         pwm1_r <= pwm_cfg_r[`GSMUX_PWM1_EN_BIT] & (pwm_cnt_r < duty1);
         pwm2_r <= pwm_cfg_r[`GSMUX_PWM2_EN_BIT] & (pwm_cnt_r < duty2);
      end
   end

   // completion pulses
   reg [2:0] hp_on_cnt_r;
   reg [2:0] hp_off_cnt_r;
   reg [2:0] boot_cnt_p_r;

   // RL13: about 100ns high per completion
   // RL25: counter runs out, pin back low
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hp_on_cnt_r <= 3'h0;
         hp_off_cnt_r <= 3'h0;
         boot_cnt_p_r <= 3'h0;
      end else begin
         if (hp_on_seq_done) begin
            hp_on_cnt_r <= PULSE_LOAD[2:0];
         end else if (hp_on_cnt_r != 3'h0) begin
            hp_on_cnt_r <= hp_on_cnt_r - 3'h1;
         end
         if (hp_off_seq_done) begin
            hp_off_cnt_r <= PULSE_LOAD[2:0];
         end else if (hp_off_cnt_r != 3'h0) begin
            hp_off_cnt_r <= hp_off_cnt_r - 3'h1;
         end
         if (boot_fin_r) begin
            boot_cnt_p_r <= PULSE_LOAD[2:0];
         end else if (boot_cnt_p_r != 3'h0) begin
            boot_cnt_p_r <= boot_cnt_p_r - 3'h1;
         end
      end
   end

   // pin mux
   // unlisted codes, including inputs, select low, which the polarity bit then inverts
   function pin_src;
      input [6:0] fn;
      begin
         case (fn)
            `GSMUX_FN_CORE_CLK: pin_src = core_clk_out;
            `GSMUX_FN_SEC_CLK: pin_src = sec_clk_out;
            `GSMUX_FN_LOOP1_CLK: pin_src = loop1_clk_out;
            `GSMUX_FN_LOOP2_CLK: pin_src = loop2_clk_out;
            `GSMUX_FN_PWM1: pin_src = pwm1_r;
            `GSMUX_FN_PWM2: pin_src = pwm2_r;
            // RL7: loop ok and lock status
            `GSMUX_FN_LOOP1_OK: pin_src = stable_r[A_OK];
            `GSMUX_FN_LOOP2_OK: pin_src = stable_r[A_OK+1];
            `GSMUX_FN_LOOP1_LOCK: pin_src = stable_r[A_LOCK];
            `GSMUX_FN_LOOP2_LOCK: pin_src = stable_r[A_LOCK+1];
            `GSMUX_FN_RCL1: pin_src = stable_r[A_RCL];
            `GSMUX_FN_RCL2: pin_src = stable_r[A_RCL+1];
            `GSMUX_FN_RERR: pin_src = rerr_r;
            `GSMUX_FN_HP_ON: pin_src = (hp_on_cnt_r != 3'h0);
            `GSMUX_FN_HP_OFF: pin_src = (hp_off_cnt_r != 3'h0);
            `GSMUX_FN_BOOT: pin_src = (boot_cnt_p_r != 3'h0);
            `GSMUX_FN_DSP1: pin_src = stable_r[A_DSP];
            `GSMUX_FN_DSP2: pin_src = stable_r[A_DSP+1];
            `GSMUX_FN_DSP3: pin_src = stable_r[A_DSP+2];
            `GSMUX_FN_DSP4: pin_src = stable_r[A_DSP+3];
            `GSMUX_FN_DSP5: pin_src = stable_r[A_DSP+4];
            `GSMUX_FN_DSP6: pin_src = stable_r[A_DSP+5];
            `GSMUX_FN_DSP7: pin_src = stable_r[A_DSP+6];
            `GSMUX_FN_DSP8: pin_src = stable_r[A_DSP+7];
            `GSMUX_FN_RAM1: pin_src = stable_r[A_RAM];
            `GSMUX_FN_RAM2: pin_src = stable_r[A_RAM+1];
            default: pin_src = 1'b0;
         endcase
      end
   endfunction

   // RL22: polarity inverts selected function
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin1_out_r <= 1'b0;
         pin1_oe_r <= 1'b0;
         pin2_out_r <= 1'b0;
         pin2_oe_r <= 1'b0;
      end else begin
         pin1_out_r <= pin_src(pin1_cfg_r[`GSMUX_FN_MSB:`GSMUX_FN_LSB]) ^
                       pin1_cfg_r[`GSMUX_POL_BIT];
         pin1_oe_r <= ~pin1_cfg_r[`GSMUX_DIR_BIT];
         pin2_out_r <= pin_src(pin2_cfg_r[`GSMUX_FN_MSB:`GSMUX_FN_LSB]) ^
                       pin2_cfg_r[`GSMUX_POL_BIT];
         pin2_oe_r <= ~pin2_cfg_r[`GSMUX_DIR_BIT];
      end
   end
endmodule // gsmux_top

// *** dv/gsmux_sva.sv ***
// port checker for the pin mux
`timescale 1ns/1ps
module gsmux_sva #(
   parameter BOOT_CYCLES = 64
) (
   input wire clock,
   input wire rst_n,
   input wire [3:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata_r,
   input wire pin1_out_r,
   input wire pin1_oe_r,
   input wire pin2_oe_r,
   input wire boot_complete_status_r,
   input wire event_pending_r
);
   reg [15:0] age_r;
   wire clr = reg_wr && reg_addr == 4'h8;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // cycles since release, saturating at the boot length
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         age_r <= 16'h0000;
      else if (age_r != BOOT_CYCLES)
         age_r <= age_r + 16'h0001;
   end
   a_read_slot_only: assert property (!$past(reg_rd) |->
      reg_rdata_r == 32'h0) else $error("read data outside slot");
   a_read_upper_zero: assert property ($past(reg_rd) |->
      reg_rdata_r[31:20] == 12'h000) else $error("upper bits set");
   a_pending_sticky: assert property (event_pending_r &&
      !$past(clr) |=> event_pending_r) else $error("pending dropped");
   a_pending_reads: assert property (event_pending_r &&
      !$past(clr) && reg_rd && reg_addr == 4'h8 |=> reg_rdata_r != 0)
      else $error("pending but status empty");
   a_boot_timing: assert property (boot_complete_status_r ==
      (age_r == BOOT_CYCLES)) else $error("boot status timing");
   a_raw_boot_bit: assert property (reg_rd && reg_addr == 4'h9
      |=> reg_rdata_r[16] == $past(boot_complete_status_r))
      else $error("raw boot bit");
   a_pin1_boot_quiet: assert property (!boot_complete_status_r
      |-> !pin1_oe_r) else $error("pin1 driven in boot");
   a_pin2_boot_quiet: assert property (!boot_complete_status_r
      |-> !pin2_oe_r) else $error("pin2 driven in boot");
   c_pend: cover property ($rose(event_pending_r));
   c_pin: cover property ($rose(pin1_out_r));
   c_boot: cover property ($rose(boot_complete_status_r));
endmodule // gsmux_sva
bind gsmux_top gsmux_sva #(.BOOT_CYCLES(BOOT_CYCLES)) u_sva (
   .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .pin1_out_r(pin1_out_r), .pin1_oe_r(pin1_oe_r),
   .pin2_oe_r(pin2_oe_r), .event_pending_r(event_pending_r),
   .boot_complete_status_r(boot_complete_status_r));

// *** dv/gsmux_pin_mon.sv ***
// external reader of a pin: period, high time, rising edges
`timescale 1ns/1ps
module gsmux_pin_mon (
   input wire pin,
   output real per,
   output real hi,
   output int edges
);
   realtime t_rise;
   initial begin
      per = 0;
      hi = 0;
      edges = 0;
      t_rise = 0;
   end
   always @(posedge pin) begin
      per = $realtime - t_rise;
      t_rise = $realtime;
      edges++;
   end
   always @(negedge pin) begin
      hi = $realtime - t_rise;
   end
endmodule // gsmux_pin_mon

// *** dv/tb_top.sv ***
// self-checking bench for the pin mux
`timescale 1ns/1ps
module tb_top;
   reg clock = 0, rst_n = 0, sclk = 0;
   reg [3:0] reg_addr = 0;
   reg [31:0] reg_wdata = 0;
   reg reg_wr = 0, reg_rd = 0, hp_on = 0, hp_off = 0;
   reg [18:0] lv = 0;
   reg [17:0] rin = 18'd8000, rout = 18'd8000;
   reg [7:0] aud_b = 8'h80;
   reg [31:0] d;
   wire [31:0] rdata;
   wire p1, p1oe, p2, p2oe, boot, pend;
   // released pad falls to the pull-down
   wire pad = p1oe ? p1 : 1'b0;
   real per, hi;
   int edges, e;
   int error_cnt = 0;
   int total_checks = 0;
   always #25 clock = ~clock;
   always #200 sclk = ~sclk;
   gsmux_top #(.BOOT_CYCLES(4), .BOOT_PIN1_CFG(10'h044)) u_dut (
      .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(rdata), .dsp_status_flag(lv[7:0]),
      .dsp_ram_ready(lv[9:8]), .loop_clock_ok(lv[11:10]),
      .loop_lock(lv[13:12]), .loop_clock({sclk, sclk}),
      .secondary_system_clock(sclk), .rate_conv_lock(lv[18:17]),
      .rate_conv_in_hz(rin), .rate_conv_out_hz(rout),
      .hp_on_seq_done(hp_on), .hp_off_seq_done(hp_off),
      .pwm_audio_a(8'h10), .pwm_audio_b(aud_b), .pin1_out_r(p1),
      .pin1_oe_r(p1oe), .pin2_out_r(p2), .pin2_oe_r(p2oe),
      .boot_complete_status_r(boot), .event_pending_r(pend));
   gsmux_pin_mon u_mon (.pin(pad), .per(per), .hi(hi), .edges(edges));
   task wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   task wr(input [3:0] a, input [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, x, s);
      end
   endtask
   task t_boot;
      wr(4'h2, 32'h111);
      repeat (20) if (!boot) wt(1);
      wt(6);
      chk("boot", boot, 1);
      chk("boot pulse", int'(hi), 100);
      chk("boot edges", edges, 1);
      rd(4'h2);
      chk("core cfg", d, 0);
      rd(4'h9);
      chk("raw boot", d[16], 1);
      rd(4'h8);
      chk("boot evt", d[16], 1);
      rd(4'h7);
      chk("unmapped", d, 0);
      wr(4'h8, 32'hfffff);
      rd(4'h8);
      chk("cleared", d, 0);
      $display("boot test done");
   endtask
   task t_levels;
      logic [6:0] fc [16] = '{7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3a,
         7'h3b, 7'h3c, 7'h46, 7'h47, 7'h0c, 7'h0d, 7'h0f, 7'h10, 7'h1a,
         7'h1b};
      int b;
      for (int i = 0; i < 16; i++) begin
         b = i < 14 ? i : i + 3;
         wr(4'h0, {1'b0, i[0], 1'b0, fc[i]});
         lv <= 19'h1 << b;
         wt(8);
         chk("oe", p1oe, 1);
         chk("pin hi", p1, !i[0]);
         rd(4'h8);
         chk("rise evt", d[b], 1);
         wr(4'h8, 32'hfffff);
         lv <= 19'h0;
         wt(8);
         chk("pin lo", p1, i[0]);
         rd(4'h8);
         chk("fall evt", d[b], b > 9);
      end
      $display("level test done");
   endtask
   task t_clk;
      wr(4'h2, 32'h111);
      wr(4'h0, 32'h004);
      wt(40);
      chk("core per", int'(per), 400);
      // enable dropped before the divider moves
      wr(4'h2, 32'h011);
      wr(4'h2, 32'h100);
      wt(20);
      chk("core fast", int'(per), 100);
      wr(4'h2, 32'h000);
      wt(3);
      e = edges;
      wt(20);
      chk("gated", edges, e);
      wr(4'h3, 32'h100);
      wr(4'h0, 32'h03d);
      wt(80);
      chk("sec per", int'(per), 800);
      wr(4'h4, 32'h1110);
      for (int n = 0; n < 2; n++) begin
         wr(4'h0, 32'h005 + n);
         wt(80);
         chk("loop per", int'(per), 800 * (n + 1));
      end
      $display("clock test done");
   endtask
   task t_pwm;
      wr(4'h6, 32'h0040);
      for (int n = 0; n < 2; n++) begin
         wr(4'h5, n ? 32'h0a : 32'h01);
         wr(4'h0, 32'h008 + n);
         wt(600);
         chk("pwm hi", int'(hi), n ? 6400 : 3200);
         chk("pwm per", int'(per), 12800);
      end
      // generators off before the core clock stops
      wr(4'h5, 32'h0);
      $display("pwm test done");
   endtask
   task t_pulse;
      for (int n = 0; n < 2; n++) begin
         wr(4'h0, 32'h02f + n);
         hp_on <= !n;
         hp_off <= n;
         wt(1);
         hp_on <= 1'b0;
         hp_off <= 1'b0;
         wt(8);
         chk("hp pulse", int'(hi), 100);
         chk("hp low", p1, 0);
         rd(4'h8);
         chk("hp evt", d[14 + n], 1);
      end
      $display("pulse test done");
   endtask
   task t_rerr;
      wr(4'h0, 32'h01c);
      wr(4'h1, 32'h11c);
      rin <= 18'd48000;
      wt(6);
      chk("rate ok", p1, 0);
      chk("pin2 inv", p2, 1);
      wr(4'h8, 32'hfffff);
      rout <= 18'd48001;
      wt(6);
      chk("rate err", p1, 1);
      chk("pin2 inv", p2, 0);
      rd(4'h8);
      chk("err evt", d[19], 1);
      $display("rate test done");
   endtask
   task test_done;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      wt(16);
      rst_n <= 1'b1;
      t_boot;
      t_levels;
      t_clk;
      t_pwm;
      t_pulse;
      t_rerr;
      test_done;
   end
   // the tests need well under ten thousand cycles
   initial begin
      wt(50000);
      error_cnt++;
      test_done;
   end
endmodule // tb_top
